// file: src/ats_sequencer.sv
// converter timing sequencer: sample window, successive approximation, load,
// reset calibration and out-of-range clamping
// assumes selects and startConv come from mclk logic; comparator flags are async
//
// Function
// [R1] basic clock is cpu clock divided by 4, 2, 16, 8 for codes 00..11
// [R2] sample window is 8, 16, 32 or 64 basic clocks per select code
// [R3] conversion lasts sample window plus 40 basic clocks plus 2 cpu clocks, exactly
// [R4] after reset calibration runs for 3328 basic clocks
// [R5] conversions allowed during calibration; calibration is extended by their time
// [R6] input below ground reads all zeros, above reference reads all ones
// [R7] after the sample window, input changes no longer affect the result
// [R8] software keeps basic clock between 0.5 and 6.25 MHz
// [R9] busy from start until result loaded, done pulse when result valid
`timescale 1ns/1ps
`default_nettype none

module ats_sequencer (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // configuration
  input  wire logic [1:0] convClockDividerSelect,
  input  wire logic [1:0] sampleWindowSelect,
  // request
  input  wire logic       startConv,
  // analog front end
  input  wire logic       compHigh,
  input  wire logic       belowGround,
  input  wire logic       aboveSupply,
  output logic            trackInput,
  output logic [9:0]      dacCode,
  // status and result
  output logic            busy,
  output logic            convDone,
  output logic [9:0]      result,
  output logic            calBusy
);

  ats_tick_if tk ();

  ats_clock_divider u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tk      (tk)
  );

  // ==========================================================================
  // synchronisers for the analog comparator flags
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic       compSync;
  logic       lowSync;
  logic       highSync;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {compHigh, belowGround, aboveSupply};
      syncB_r <= syncA_r;
    end
  end

  assign compSync = syncB_r[2];
  assign lowSync  = syncB_r[1];
  assign highSync = syncB_r[0];

  // ==========================================================================
  // state and counters
  ats_pkg::ats_state_type state_r;
  ats_pkg::ats_state_type state_nxt;
  logic [6:0]  bcCnt_r;
  logic [6:0]  bcCnt_nxt;
  logic [1:0]  loadCnt_r;
  logic [6:0]  smpLen_r;
  logic [6:0]  smpLen;
  logic [9:0]  code_r;
  logic [9:0]  code_nxt;
  logic [9:0]  mask_r;
  logic [9:0]  mask_nxt;
  logic        clampLow_r;
  logic        clampHigh_r;
  logic [9:0]  result_r;
  logic        done_r;
  logic [11:0] calCnt_r;
  logic        calBusy_r;

  logic idle;
  logic start;
  logic smpEnd;
  logic convEnd;
  logic bitStep;
  logic loadEnd;
  logic calStep;
  logic calEnd;

  // ==========================================================================
  // decode
  assign smpLen = (sampleWindowSelect == ats_pkg::SMPSEL_8)  ? ats_pkg::SMP_8  :
                  (sampleWindowSelect == ats_pkg::SMPSEL_16) ? ats_pkg::SMP_16 :
                  (sampleWindowSelect == ats_pkg::SMPSEL_32) ? ats_pkg::SMP_32 :
                                                               ats_pkg::SMP_64; // [R2]

  assign idle    = (state_r == ats_pkg::IDLE);
  // a request while busy is ignored; there is no queue
  assign start   = idle && startConv;
  assign smpEnd  = (state_r == ats_pkg::SAMPLE) && tk.tick &&
                   (bcCnt_r == smpLen_r - 7'h01);                         // [R2]
  assign convEnd = (state_r == ats_pkg::CONVERT) && tk.tick &&
                   (bcCnt_r == ats_pkg::CONV_BC - 7'h01);                 // [R3]
  assign bitStep = (state_r == ats_pkg::CONVERT) && tk.tick &&
                   (bcCnt_r[1:0] == ats_pkg::STEP_LAST);
  assign loadEnd = (state_r == ats_pkg::LOAD) &&
                   (loadCnt_r == ats_pkg::LOAD_CYC - 2'h1);               // [R3]

  // calibration only advances while no conversion holds the converter
  assign calStep = calBusy_r && idle && !startConv && tk.tick;            // [R5]
  assign calEnd  = calStep && (calCnt_r == ats_pkg::CAL_BC - 12'h001);    // [R4]

  assign tk.restart = start;                                              // [R3]
  assign tk.divSel  = convClockDividerSelect;                             // [R1]

  // ==========================================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    bcCnt_nxt = bcCnt_r;
    case (state_r)
      ats_pkg::IDLE: begin
        bcCnt_nxt = 7'h00;
        if (start) state_nxt = ats_pkg::SAMPLE;
      end
      ats_pkg::SAMPLE: begin
        if (smpEnd) begin
          state_nxt = ats_pkg::CONVERT;
          bcCnt_nxt = 7'h00;
        end else if (tk.tick) begin
          bcCnt_nxt = bcCnt_r + 7'h01;
        end
      end
      ats_pkg::CONVERT: begin
        if (convEnd) begin
          state_nxt = ats_pkg::LOAD;
          bcCnt_nxt = 7'h00;
        end else if (tk.tick) begin
          bcCnt_nxt = bcCnt_r + 7'h01;
        end
      end
      ats_pkg::LOAD: begin
        if (loadEnd) state_nxt = ats_pkg::IDLE;
      end
      default: begin
        state_nxt = ats_pkg::IDLE;
        bcCnt_nxt = 7'h00;
      end
    endcase
  end

  // ==========================================================================
  // successive approximation: keep the trial bit when the input is above it
  assign mask_nxt = (state_r == ats_pkg::SAMPLE) ? ats_pkg::CODE_MSB :
                    bitStep ? (mask_r >> 1) : mask_r;
  assign code_nxt = (state_r == ats_pkg::SAMPLE) ? ats_pkg::CODE_MSB :
                    bitStep ? (((compSync ? code_r : (code_r & ~mask_r))) | (mask_r >> 1))
                            : code_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ats_pkg::IDLE;
      bcCnt_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      bcCnt_r <= bcCnt_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      code_r <= ats_pkg::CODE_MIN;
      mask_r <= ats_pkg::CODE_MIN;
    end else begin
      code_r <= code_nxt;
      mask_r <= mask_nxt;
    end
  end

  // window length is frozen at start so a select change cannot stretch it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)    smpLen_r <= ats_pkg::SMP_8;
    else if (start) smpLen_r <= smpLen;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)                         loadCnt_r <= 2'h0;
    else if (state_r == ats_pkg::LOAD)   loadCnt_r <= loadCnt_r + 2'h1;
    else                                 loadCnt_r <= 2'h0;
  end

  // range flags are frozen with the sample, like the held input itself
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clampLow_r  <= 1'b0;
      clampHigh_r <= 1'b0;
    end else if (smpEnd) begin
      clampLow_r  <= lowSync;                                             // [R7]
      clampHigh_r <= highSync;                                            // [R7]
    end
  end

  // ==========================================================================
  // result load with out-of-range clamping
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= ats_pkg::CODE_MIN;
      done_r   <= 1'b0;
    end else begin
      done_r <= loadEnd;                                                  // [R9]
      if (loadEnd) begin
        if (clampLow_r)       result_r <= ats_pkg::CODE_MIN;              // [R6]
        else if (clampHigh_r) result_r <= ats_pkg::CODE_MAX;              // [R6]
        else                  result_r <= code_r;
      end
    end
  end

  // ==========================================================================
  // reset calibration timer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      calCnt_r  <= 12'h000;
      calBusy_r <= 1'b1;                                                  // [R4]
    end else if (calEnd) begin
      calBusy_r <= 1'b0;                                                  // [R4]
    end else if (calStep) begin
      calCnt_r  <= calCnt_r + 12'h001;                                    // [R5]
    end
  end

  // ==========================================================================
  // outputs
  assign trackInput = (state_r == ats_pkg::SAMPLE);                       // [R7]
  assign dacCode    = code_r;
  assign busy       = !idle;                                              // [R9]
  assign convDone   = done_r;
  assign result     = result_r;
  assign calBusy    = calBusy_r;

endmodule

`default_nettype wire

// file: src/ats_pkg.sv
// constants shared by the converter timing sequencer and its basic-clock divider
// assumes one cpu clock domain (mclk) for all users
package ats_pkg;

  // ==========================================================================
  // result format
  localparam int        RES_W    = 10;
  localparam logic [9:0] CODE_MIN = 10'h000;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [9:0] CODE_MSB = 10'h200;

  // ==========================================================================
  // basic clock divider: select code to cpu cycles per basic clock
  localparam logic [1:0] DIVSEL_4  = 2'h0;
  localparam logic [1:0] DIVSEL_2  = 2'h1;
  localparam logic [1:0] DIVSEL_16 = 2'h2;
  localparam logic [1:0] DIVSEL_8  = 2'h3;
  localparam logic [4:0] DIV_4     = 5'h04;
  localparam logic [4:0] DIV_2     = 5'h02;
  localparam logic [4:0] DIV_16    = 5'h10;
  localparam logic [4:0] DIV_8     = 5'h08;

  // ==========================================================================
  // sample window in basic clocks per select code
  localparam logic [1:0] SMPSEL_8  = 2'h0;
  localparam logic [1:0] SMPSEL_16 = 2'h1;
  localparam logic [1:0] SMPSEL_32 = 2'h2;
  localparam logic [1:0] SMPSEL_64 = 2'h3;
  localparam logic [6:0] SMP_8     = 7'h08;
  localparam logic [6:0] SMP_16    = 7'h10;
  localparam logic [6:0] SMP_32    = 7'h20;
  localparam logic [6:0] SMP_64    = 7'h40;

  // ==========================================================================
  // conversion and calibration timing
  localparam logic [6:0]  CONV_BC   = 7'h28;   // bit determination, basic clocks
  localparam logic [1:0]  STEP_LAST = 2'h3;    // four basic clocks per result bit
  localparam logic [1:0]  LOAD_CYC  = 2'h2;    // result load, cpu cycles
  localparam logic [11:0] CAL_BC    = 12'hd00; // reset calibration, basic clocks

  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, LOAD} ats_state_type;

endpackage

// file: src/ats_tick_if.sv
// carrier between the sequencer and the basic clock divider
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none

interface ats_tick_if;
  logic       restart;
  logic [1:0] divSel;
  logic       tick;

  modport sequencer (output restart, output divSel, input tick);
  modport divider   (input restart, input divSel, output tick);
endinterface

`default_nettype wire

// file: src/ats_clock_divider.sv
// basic clock divider: one-cycle tick enable at mclk / 2, 4, 8 or 16
// assumes divSel is steady while a conversion runs
`timescale 1ns/1ps
`default_nettype none

module ats_clock_divider (
  // clock and reset
  input  wire logic    mclk,
  input  wire logic    sys_rst,
  // towards the sequencer
  ats_tick_if.divider  tk
);

  logic [4:0] divisor;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       wrap;

  // ==========================================================================
  // divisor decode
  assign divisor = (tk.divSel == ats_pkg::DIVSEL_4)  ? ats_pkg::DIV_4  :
                   (tk.divSel == ats_pkg::DIVSEL_2)  ? ats_pkg::DIV_2  :
                   (tk.divSel == ats_pkg::DIVSEL_16) ? ats_pkg::DIV_16 :
                                                       ats_pkg::DIV_8;  // [R1]

  // restart aligns the first tick exactly one divisor after the start cycle
  assign wrap    = (cnt_r >= divisor - 5'h01);
  assign tk.tick = !tk.restart && wrap;
  assign cnt_nxt = (tk.restart || wrap) ? 5'h00 : cnt_r + 5'h01;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) cnt_r <= 5'h00;
    else         cnt_r <= cnt_nxt;
  end

endmodule

`default_nettype wire

// file: tb/ats_sequencer_sva.sv
// checker for the converter timing sequencer, ports of ats_sequencer only
// assumes one mclk domain and selects held steady while busy
`timescale 1ns/1ps
`default_nettype none

module ats_sequencer_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // configuration and request
  input wire logic [1:0] convClockDividerSelect,
  input wire logic [1:0] sampleWindowSelect,
  input wire logic       startConv,
  // outputs watched
  input wire logic       trackInput,
  input wire logic [9:0] dacCode,
  input wire logic       busy,
  input wire logic       convDone,
  input wire logic [9:0] result,
  input wire logic       calBusy
);
  logic [11:0] divW;
  logic [11:0] smpW;
  logic [11:0] trackCnt_r;
  logic [11:0] busyCnt_r;

  // ==========================================================================
  // expected spans, counted in mclk cycles
  assign divW = convClockDividerSelect[0] ? (convClockDividerSelect[1] ? 12'h008 : 12'h002)
                                          : (convClockDividerSelect[1] ? 12'h010 : 12'h004);
  assign smpW = 12'h008 << sampleWindowSelect;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trackCnt_r <= 12'h000;
      busyCnt_r  <= 12'h000;
    end else begin
      trackCnt_r <= trackInput ? trackCnt_r + 12'h001 : 12'h000;
      busyCnt_r  <= busy ? busyCnt_r + 12'h001 : 12'h000;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_done_pulse: assert property (convDone |=> !convDone)
    else $error("done pulse longer than one cycle");
  // the first trial code is loaded one edge after sampling begins
  a_start_busy: assert property (startConv && !busy |=> busy && trackInput ##1
    dacCode == 10'h200)
    else $error("start did not begin sampling");
  a_conv_len: assert property (convDone |-> !busy &&
    busyCnt_r == (smpW + 12'h028) * divW + 12'h002)
    else $error("conversion length wrong");
  a_busy_end: assert property ($fell(busy) |-> convDone)
    else $error("busy fell without done");
  a_track_len: assert property ($fell(trackInput) |-> trackCnt_r == smpW * divW)
    else $error("sample window length wrong");
  a_track_busy: assert property (trackInput |-> busy)
    else $error("sampling outside a conversion");
  a_cal_once: assert property (!$rose(calBusy))
    else $error("calibration restarted without reset");
  a_result_hold: assert property ($changed(result) |-> convDone)
    else $error("result changed without done");
endmodule

bind ats_sequencer ats_sequencer_sva i_ats_sequencer_sva (
  .mclk(mclk), .sys_rst(sys_rst), .convClockDividerSelect(convClockDividerSelect),
  .sampleWindowSelect(sampleWindowSelect), .startConv(startConv), .trackInput(trackInput),
  .dacCode(dacCode), .busy(busy), .convDone(convDone), .result(result), .calBusy(calBusy));

`default_nettype wire

// file: tb/test_adc_timing_sequencer.sv
// self-checking bench for ats_sequencer
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none

module test_adc_timing_sequencer;
  logic       mclk, sys_rst, startConv, compHigh, belowGround, aboveSupply;
  logic       trackInput, busy, convDone, calBusy;
  logic [1:0] divSel, smpSel;
  logic [9:0] dacCode, result, target;
  int         failures, num_checks;
  int         divTab[4] = '{4, 2, 16, 8};

  ats_sequencer i_ats_sequencer (.mclk(mclk), .sys_rst(sys_rst),
    .convClockDividerSelect(divSel), .sampleWindowSelect(smpSel), .startConv(startConv),
    .compHigh(compHigh), .belowGround(belowGround), .aboveSupply(aboveSupply),
    .trackInput(trackInput), .dacCode(dacCode), .busy(busy), .convDone(convDone),
    .result(result), .calBusy(calBusy));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // comparator: the input sits half a code above target
  always @(posedge mclk) compHigh <= (target >= dacCode);

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // selects settle one edge ahead of the request; n counts edges to done
  task automatic conv(input logic [1:0] d, input logic [1:0] s, output int n);
    @(posedge mclk);
    divSel <= d;
    smpSel <= s;
    @(posedge mclk);
    startConv <= 1'b1;
    @(posedge mclk);
    startConv <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (convDone !== 1'b1 && n < 3000);
  endtask

  task automatic t_cal;
    int      n;
    realtime t0;
    t0 = $realtime;
    // only code 10 keeps the basic clock in range at 100 mhz; the other scenarios trade
    // that for run time, as the sequencer itself does not depend on the absolute rate
    conv(2'h2, 2'h0, n);
    chk("cal_conv", 16'((8 + 40) * 16 + 2), n[15:0]);
    while (calBusy === 1'b1 && $realtime - t0 < 600000) begin
      @(posedge mclk);
      #1;
    end
    n = int'(($realtime - t0) / 10.0) - 3328 * 16 - ((8 + 40) * 16 + 3);
    chk("cal_len", 16'h1, {15'h0, n >= -6 && n <= 6});
  endtask

  task automatic t_timing;
    int n;
    for (int i = 0; i < 4; i++) begin
      conv(i[1:0], i[1:0], n);
      chk("conv_len", 16'(((8 << i) + 40) * divTab[i] + 2), n[15:0]);
      chk("busy_done", 16'h0, {15'h0, busy});
    end
  endtask

  task automatic t_clamp;
    int n;
    // a nonzero code so that a missing low clamp shows up
    @(posedge mclk);
    target <= 10'h155;
    for (int k = 1; k < 4; k++) begin
      @(posedge mclk);
      {aboveSupply, belowGround} <= k[1:0];
      conv(2'h1, 2'h1, n);
      chk("clamp", k[0] ? 16'h000 : 16'h3ff, {6'h0, result});
    end
  endtask

  task automatic t_hold;
    int n;
    @(posedge mclk);
    {aboveSupply, belowGround} <= 2'b10;
    fork
      conv(2'h1, 2'h0, n);
      begin
        repeat (24) @(posedge mclk);
        {aboveSupply, belowGround} <= 2'b01;
      end
    join
    chk("hold", 16'h3ff, {6'h0, result});
    @(posedge mclk);
    {aboveSupply, belowGround} <= 2'b00;
  endtask

  task automatic t_sar;
    int         n;
    logic [9:0] tv[3] = '{10'h155, 10'h2aa, 10'h3fe};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      target <= tv[i];
      conv(2'h1, 2'h0, n);
      chk("sar", {6'h0, tv[i]}, {6'h0, result});
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    startConv = 1'b0;
    belowGround = 1'b0;
    aboveSupply = 1'b0;
    divSel = 2'h2;
    smpSel = 2'h0;
    target = 10'h000;
    repeat (10) @(posedge mclk);
    #1;
    chk("rst_flags", 16'h1, {12'h0, busy, convDone, trackInput, calBusy});
    chk("rst_result", 16'h0, {6'h0, result});
    @(posedge mclk);
    sys_rst <= 1'b0;
    t_cal();
    t_timing();
    t_clamp();
    t_hold();
    t_sar();
    summarize();
  end

  // whole run needs about 57000 cycles, mostly the reset calibration at divide by 16
  initial begin
    #800000;
    failures++;
    summarize();
  end
endmodule

`default_nettype wire
